// file: hw/address_breakpoint_unit.sv
// Design decision made here: the Avalon-MM register port.
`include "brk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module address_breakpoint_unit (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // Avalon-MM register slave
   input  wire logic [17:0]       avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // CPU core and system integration side
   input  wire brk_pkg::cpu_bus_t cpu_bus,
   input  wire logic              monitor_mode,
   input  wire logic              wait_exit_by_break,
   output brk_pkg::break_cmd_t    break_cmd,
   output logic                   break_state,
   output logic                   watchdog_disable,
   output logic                   status_clear_allowed,
   // Interrupt
   output logic                   irq
);

   // ****************************************************************
   // Reset synchroniser
   // ****************************************************************

   logic rst_meta_ff;
   logic rst_n_ff;

   // Assertion is immediate; release waits two edges so that every
   // flip-flop below leaves reset on one common clock edge
   // Release of reset passes two flip-flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // ****************************************************************
   // Declarations
   // ****************************************************************

   logic [7:0]               addr_high_ff;
   logic [7:0]               addr_low_ff;
   logic                     enable_ff;
   logic                     active_ff;
   logic                     wait_exit_ff;
   logic                     clear_en_ff;
   logic                     armed_ff;
   logic                     pending_ff;
   logic                     brk_state_ff;
   logic [`BRK_EVT_W-1:0]    evt_status_ff;
   logic [`BRK_EVT_W-1:0]    evt_mask_ff;
   logic                     irq_ff;
   logic                     waitreq_ff;
   logic [31:0]              rdata_ff;
   brk_pkg::break_cmd_t      cmd_ff;
   logic                     wdog_off_ff;
   logic                     clr_allow_ff;

   logic                     acc_done;
   logic                     wr_lo;
   logic [15:0]              acc_idx;
   logic [7:0]               wbyte;
   logic                     addr_hit;
   logic                     hit_opcode;
   logic                     hit_operand;
   logic                     soft_break;
   logic                     take;
   logic                     rti_end;
   logic [`BRK_EVT_W-1:0]    evt_set;
   logic [31:0]              nxt_rdata;

   // ****************************************************************
   // Register decode
   // ****************************************************************

   // True when a write hits the given register index
   function automatic logic wr_hit(input logic [15:0] idx, input logic [15:0] reg_idx,
                                   input logic wr);
      wr_hit = wr && (idx == reg_idx);
   endfunction

   // Access completes at the edge where waitrequest is sampled low
   // Only byte lane 0 carries register data; other lanes are ignored
   assign acc_done = (avs_read || avs_write) && !waitreq_ff;
   assign wr_lo    = avs_write && !waitreq_ff && avs_byteenable[0];
   assign acc_idx  = avs_address[17:2];
   assign wbyte    = avs_writedata[7:0];

   // ****************************************************************
   // Break detection
   // ****************************************************************

   assign addr_hit = enable_ff && armed_ff && cpu_bus.pc_gen
                     && (cpu_bus.addr == {addr_high_ff, addr_low_ff});

   assign hit_opcode  = addr_hit && cpu_bus.opcode_fetch;
   assign hit_operand = addr_hit && !cpu_bus.opcode_fetch;

   assign soft_break = wr_hit(acc_idx, `BRK_IDX_CTRL_STATUS, wr_lo)
                       && wbyte[`BRK_BIT_ACTIVE];

   // No new break is taken while one is being serviced
   // next instruction
   assign take = !brk_state_ff
                 && (hit_opcode || (pending_ff && cpu_bus.instr_start));

   assign rti_end = brk_state_ff && cpu_bus.rti_exec;

   // Events feeding the interrupt status
   // Bit 0 records any enabled match, also one that only sets pending
   assign evt_set[`BRK_EVT_ADDR] = addr_hit;
   assign evt_set[`BRK_EVT_SOFT] = soft_break;
   assign evt_set[`BRK_EVT_END]  = rti_end;
   assign evt_set[`BRK_EVT_WAIT] = wait_exit_by_break;

   // Break deferred to the next instruction boundary
   // A set in the same cycle as a take keeps the request for the next
   // boundary, so a software break during a match is not lost
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pending_ff <= 1'b0;
      end else if (hit_operand || soft_break) begin
         pending_ff <= 1'b1;
      end else if (take) begin
         pending_ff <= 1'b0;
      end
   end

   // A match while ACTIVE is clear disarms the unit, so the resumed opcode fetch at the same
   // address does not break twice; writing either address byte rearms it
   // rearm on new address
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         armed_ff <= 1'b1;
      end else if (wr_hit(acc_idx, `BRK_IDX_ADDR_HIGH, wr_lo)
                   || wr_hit(acc_idx, `BRK_IDX_ADDR_LOW, wr_lo)) begin
         armed_ff <= 1'b1;
      end else if (addr_hit && !active_ff) begin
         armed_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Break state and commands
   // ****************************************************************

   // Break state runs from take to return-from-interrupt
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         brk_state_ff <= 1'b0;
      end else if (take) begin
         brk_state_ff <= 1'b1;
      end else if (rti_end) begin
         brk_state_ff <= 1'b0;
      end
   end

   // Vector follows the monitor mode level of the previous cycle
   // one-cycle pulse
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cmd_ff.breakpoint_request <= 1'b0;
         cmd_ff.load_swi           <= 1'b0;
         cmd_ff.vector_addr        <= `BRK_VEC_NORMAL;
      end else begin
         cmd_ff.breakpoint_request <= take;
         cmd_ff.load_swi           <= take;
         cmd_ff.vector_addr        <= monitor_mode ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL;
      end
   end

   // Both gates follow the break state as it stands after this edge
   // watchdog off
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wdog_off_ff  <= 1'b0;
         clr_allow_ff <= 1'b1;
      end else begin
         wdog_off_ff  <= take || (brk_state_ff && !rti_end);
         clr_allow_ff <= !(take || (brk_state_ff && !rti_end)) || clear_en_ff;
      end
   end

   // ****************************************************************
   // Break registers
   // ****************************************************************

   // Break address bytes
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         addr_high_ff <= `BRK_RST_BYTE;
         addr_low_ff  <= `BRK_RST_BYTE;
      end else begin
         if (wr_hit(acc_idx, `BRK_IDX_ADDR_HIGH, wr_lo)) begin
            addr_high_ff <= wbyte;
         end
         if (wr_hit(acc_idx, `BRK_IDX_ADDR_LOW, wr_lo)) begin
            addr_low_ff <= wbyte;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         enable_ff <= 1'b0;
      end else if (wr_hit(acc_idx, `BRK_IDX_CTRL_STATUS, wr_lo)) begin
         enable_ff <= wbyte[`BRK_BIT_ENABLE];
      end
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         active_ff <= 1'b0;
      end else if (addr_hit || soft_break) begin
         active_ff <= 1'b1;
      end else if (wr_hit(acc_idx, `BRK_IDX_CTRL_STATUS, wr_lo)) begin
         active_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wait_exit_ff <= 1'b0;
      end else if (wait_exit_by_break) begin
         wait_exit_ff <= 1'b1;
      end else if (wr_hit(acc_idx, `BRK_IDX_WAIT_STATUS, wr_lo)
                   && !wbyte[`BRK_BIT_WAIT_EXIT]) begin
         wait_exit_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         clear_en_ff <= 1'b0;
      end else if (wr_hit(acc_idx, `BRK_IDX_FLAG_CLEAR, wr_lo)) begin
         clear_en_ff <= wbyte[`BRK_BIT_CLEAR_EN];
      end
   end

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************

   // Sticky event bits, write one to clear, set wins
   genvar gi;
   generate
      for (gi = 0; gi < `BRK_EVT_W; gi = gi + 1) begin : g_evt
         always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
               evt_status_ff[gi] <= 1'b0;
            end else if (evt_set[gi]) begin
               evt_status_ff[gi] <= 1'b1;
            end else if (wr_hit(acc_idx, `BRK_IDX_EVT_STATUS, wr_lo) && wbyte[gi]) begin
               evt_status_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Mask register
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         evt_mask_ff <= `BRK_RST_EVT;
      end else if (wr_hit(acc_idx, `BRK_IDX_EVT_MASK, wr_lo)) begin
         evt_mask_ff <= wbyte[`BRK_EVT_W-1:0];
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(evt_status_ff & evt_mask_ff);
      end
   end

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************

   // Reserved and unused indices read as zero; writes to them are dropped
   // access never gated by break
   always_comb begin
      nxt_rdata = `BRK_RST_WORD;
      case (acc_idx)
         `BRK_IDX_WAIT_STATUS: nxt_rdata[`BRK_BIT_WAIT_EXIT] = wait_exit_ff;
         `BRK_IDX_FLAG_CLEAR:  nxt_rdata[`BRK_BIT_CLEAR_EN]  = clear_en_ff;
         `BRK_IDX_ADDR_HIGH:   nxt_rdata[7:0]                = addr_high_ff;
         `BRK_IDX_ADDR_LOW:    nxt_rdata[7:0]                = addr_low_ff;
         `BRK_IDX_CTRL_STATUS: begin
            nxt_rdata[`BRK_BIT_ENABLE] = enable_ff;
            nxt_rdata[`BRK_BIT_ACTIVE] = active_ff;
         end
         `BRK_IDX_EVT_STATUS:  nxt_rdata[`BRK_EVT_W-1:0]     = evt_status_ff;
         `BRK_IDX_EVT_MASK:    nxt_rdata[`BRK_EVT_W-1:0]     = evt_mask_ff;
         default:              nxt_rdata                     = `BRK_RST_WORD;
      endcase
   end

   // One wait cycle, then one cycle with waitrequest low
   // Read data is captured in the wait cycle and stands while waitrequest
   // is low; a write lands at the edge where waitrequest is sampled low
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         waitreq_ff <= 1'b1;
         rdata_ff   <= `BRK_RST_WORD;
      end else if (acc_done) begin
         waitreq_ff <= 1'b1;
      end else if (avs_read || avs_write) begin
         waitreq_ff <= 1'b0;
         rdata_ff   <= avs_read ? nxt_rdata : `BRK_RST_WORD;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output is driven straight from a flip-flop
   assign avs_readdata         = rdata_ff;
   assign avs_waitrequest      = waitreq_ff;
   assign break_cmd            = cmd_ff;
   assign break_state          = brk_state_ff;
   assign watchdog_disable     = wdog_off_ff;
   assign status_clear_allowed = clr_allow_ff;
   assign irq                  = irq_ff;

endmodule

`default_nettype wire

// file: hw/brk_cfg.svh
`ifndef BRK_CFG_SVH
`define BRK_CFG_SVH

// Register indices; the byte address is four times the index
`define BRK_IDX_WAIT_STATUS   16'hfe00
`define BRK_IDX_RESERVED      16'hfe02
`define BRK_IDX_FLAG_CLEAR    16'hfe03
`define BRK_IDX_ADDR_HIGH     16'hfe09
`define BRK_IDX_ADDR_LOW      16'hfe0a
`define BRK_IDX_CTRL_STATUS   16'hfe0b
`define BRK_IDX_EVT_STATUS    16'hfe10
`define BRK_IDX_EVT_MASK      16'hfe11

// Field positions
`define BRK_BIT_ENABLE        7
`define BRK_BIT_ACTIVE        6
`define BRK_BIT_WAIT_EXIT     1
`define BRK_BIT_CLEAR_EN      7

// Reset values
`define BRK_RST_BYTE          8'h00
`define BRK_RST_EVT           4'h0
`define BRK_RST_WORD          32'h0000_0000

// Break vectors, normal and monitor mode
`define BRK_VEC_NORMAL        16'hfffc
`define BRK_VEC_MONITOR       16'hfefc

// Event status and mask layout
`define BRK_EVT_W             4
`define BRK_EVT_ADDR          0
`define BRK_EVT_SOFT          1
`define BRK_EVT_END           2
`define BRK_EVT_WAIT          3

`endif

// file: hw/brk_pkg.sv
`default_nettype none
package brk_pkg;

   // CPU core and system integration view of the internal bus
   typedef struct packed {
      logic [15:0] addr;          // Internal address bus
      logic        pc_gen;        // Address comes from the program counter
      logic        opcode_fetch;  // Cycle fetches an opcode
      logic        instr_start;   // Next instruction is about to begin
      logic        rti_exec;      // Return-from-interrupt executes
   } cpu_bus_t;

   // Break commands to the system integration logic
   typedef struct packed {
      logic        breakpoint_request;
      logic        load_swi;
      logic [15:0] vector_addr;
   } break_cmd_t;

endpackage
`default_nettype wire

// file: bench/cpu_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// CPU core and system logic model
// ********************************
module cpu_partner (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                nrst,
   // Bench control
   input  wire logic                run,
   // Break link
   input  wire brk_pkg::break_cmd_t break_cmd,
   input  wire logic                break_state,
   output brk_pkg::cpu_bus_t        cpu_bus
);
   logic [15:0] pc_ff;
   logic [15:0] vec_ff;
   logic [1:0]  ph_ff;
   logic [4:0]  svc_ff;
   wire         live = run && (svc_ff == 5'h00);

   // vector on a break, resume at the last opcode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_ff  <= 16'h8000;
         vec_ff <= 16'h0000;
         ph_ff  <= 2'h0;
         svc_ff <= 5'h00;
      end else if (break_cmd.breakpoint_request) begin
         vec_ff <= break_cmd.vector_addr;
         ph_ff  <= 2'h0;
         svc_ff <= 5'h1f;
      end else if (svc_ff != 5'h00) begin
         svc_ff <= svc_ff - 5'h01;
      end else if (run) begin
         ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
         if (ph_ff == 2'h2) begin
            pc_ff <= (pc_ff == 16'h800e) ? 16'h8000 : pc_ff + 16'h0002;
         end
      end
   end

   // opcode, operand, data cycles; return only inside the routine
   always_comb begin
      cpu_bus.addr         = (ph_ff == 2'h2) ? 16'h0040 : pc_ff + {15'h0000, ph_ff[0]};
      if (svc_ff != 5'h00) cpu_bus.addr = vec_ff;
      cpu_bus.pc_gen       = live && (ph_ff != 2'h2);
      cpu_bus.opcode_fetch = live && (ph_ff == 2'h0);
      cpu_bus.instr_start  = live && (ph_ff == 2'h0);
      cpu_bus.rti_exec     = break_state && (svc_ff == 5'h01);
   end
endmodule
`default_nettype wire

// file: bench/brk_chk.sv
`include "brk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module brk_chk (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                nrst,
   // Register bus
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic                avs_waitrequest,
   // Break link
   input  wire brk_pkg::cpu_bus_t   cpu_bus,
   input  wire logic                monitor_mode,
   input  wire brk_pkg::break_cmd_t break_cmd,
   input  wire logic                break_state,
   input  wire logic                watchdog_disable,
   input  wire logic                status_clear_allowed,
   input  wire logic                irq
);
   // ********************************
   // Break link and register bus checks
   // ********************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire req = break_cmd.breakpoint_request;

   property p_pulse; req |=> !req; endproperty
   a_pulse: assert property (p_pulse) else $error("request held too long");
   property p_swi; req == break_cmd.load_swi; endproperty
   a_swi: assert property (p_swi) else $error("insert strobe differs");
   property p_vec;
      req |-> break_cmd.vector_addr == ($past(monitor_mode) ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL);
   endproperty
   a_vec: assert property (p_vec) else $error("wrong vector");
   property p_take; req |-> break_state && !$past(break_state); endproperty
   a_take: assert property (p_take) else $error("break taken inside routine");
   property p_hold; $rose(break_state) |-> req; endproperty
   a_hold: assert property (p_hold) else $error("break state without request");
   property p_rti; break_state && cpu_bus.rti_exec |=> !break_state; endproperty
   a_rti: assert property (p_rti) else $error("return did not end break");
   property p_wdog; watchdog_disable == break_state; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog gate wrong");
   property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   property p_clr; !status_clear_allowed |-> break_state || $past(break_state); endproperty
   a_clr: assert property (p_clr) else $error("clearing blocked outside break");

   // Main scenarios
   c_brk: cover property (req);
   c_rti: cover property (break_state && cpu_bus.rti_exec);
   c_irq: cover property ($rose(irq));
endmodule
bind address_breakpoint_unit brk_chk u_chk (.clk(clk), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cpu_bus(cpu_bus),
   .monitor_mode(monitor_mode), .break_cmd(break_cmd), .break_state(break_state),
   .watchdog_disable(watchdog_disable), .status_clear_allowed(status_clear_allowed), .irq(irq));
`default_nettype wire

// file: bench/test_address_breakpoint_unit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_address_breakpoint_unit;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic [17:0]         avs_address = 18'h00000;
   logic                avs_read = 1'b0;
   logic                avs_write = 1'b0;
   logic [31:0]         avs_writedata = 32'h0000_0000;
   logic [3:0]          avs_byteenable = 4'h1;
   logic [31:0]         avs_readdata;
   logic                avs_waitrequest;
   brk_pkg::cpu_bus_t   cpu_bus;
   logic                monitor_mode = 1'b0;
   logic                wait_exit_by_break = 1'b0;
   brk_pkg::break_cmd_t break_cmd;
   logic                break_state, watchdog_disable, status_clear_allowed, irq;
   logic                run = 1'b0;
   logic [15:0]         last_addr, hit_addr;
   logic                last_of, hit_of;
   logic [7:0]          rd;
   int                  error_cnt = 0;
   int                  checks = 0;
   int                  brk_cnt = 0;
   int                  n0;

   address_breakpoint_unit dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cpu_bus(cpu_bus), .monitor_mode(monitor_mode),
      .wait_exit_by_break(wait_exit_by_break), .break_cmd(break_cmd),
      .break_state(break_state), .watchdog_disable(watchdog_disable),
      .status_clear_allowed(status_clear_allowed), .irq(irq));
   cpu_partner u_cpu (.clk(clk), .nrst(nrst), .run(run), .break_cmd(break_cmd),
      .break_state(break_state), .cpu_bus(cpu_bus));

   always #2.5 clk = ~clk;

   // Record the bus cycle at each taking edge
   always @(posedge clk) begin
      if (break_cmd.breakpoint_request === 1'b1) begin
         brk_cnt  <= brk_cnt + 1;
         hit_addr <= last_addr;
         hit_of   <= last_of;
      end
      last_addr <= cpu_bus.addr;
      last_of   <= cpu_bus.opcode_fetch;
   end

   // ********************************
   // Bus and wait helpers
   // ********************************
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk);
      avs_address   <= {idx, 2'b00};
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= {24'h00_0000, wd};
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      `CHK("answer", 1'b1, n < 50)
   endtask
   task automatic rchk(input logic [15:0] idx, input logic [7:0] ex);
      bus(1'b0, idx, 8'h00);
      `CHK("register", ex, rd)
   endtask
   task automatic wait_ev(input bit brk);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         if (brk ? (break_cmd.breakpoint_request === 1'b1) : (break_state === 1'b0)) break;
      end
      `CHK("event", 1'b1, n < 300)
      @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ********************************
   // Scenarios
   // ********************************
   task automatic t_regs;
      rchk(16'hfe0b, 8'h00);
      rchk(16'hfe09, 8'h00);
      rchk(16'hfe0a, 8'h00);
      rchk(16'hfe03, 8'h00);
      bus(1'b1, 16'hfe02, 8'hff);
      rchk(16'hfe02, 8'h00);
      rchk(16'h0123, 8'h00);
   endtask
   task automatic t_match;
      bus(1'b1, 16'hfe10, 8'h0f);
      bus(1'b1, 16'hfe11, 8'h01);
      bus(1'b1, 16'hfe09, 8'h80);
      bus(1'b1, 16'hfe0a, 8'h04);
      bus(1'b1, 16'hfe0b, 8'h80);
      run <= 1'b1;
      wait_ev(1'b1);
      `CHK("hit", 16'h8004, hit_addr)
      `CHK("vector", 16'hfffc, break_cmd.vector_addr)
      `CHK("clear gate", 1'b0, status_clear_allowed)
      rchk(16'hfe0b, 8'hc0);
      bus(1'b1, 16'hfe03, 8'h80);
      repeat (2) @(posedge clk);
      `CHK("clear gate", 1'b1, status_clear_allowed)
      bus(1'b1, 16'hfe03, 8'h00);
      bus(1'b1, 16'hfe0a, 8'h08);
      bus(1'b1, 16'hfe0b, 8'h80);
      wait_ev(1'b0);
      wait_ev(1'b1);
      `CHK("hit", 16'h8008, hit_addr)
      bus(1'b1, 16'hfe0b, 8'h00);
      wait_ev(1'b0);
      `CHK("irq", 1'b1, irq)
      rchk(16'hfe10, 8'h05);
      bus(1'b1, 16'hfe11, 8'h00);
      repeat (2) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, 16'hfe11, 8'h01);
      bus(1'b1, 16'hfe10, 8'h0f);
      repeat (2) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, 16'hfe0a, 8'h08);
      repeat (60) @(posedge clk);
      `CHK("breaks", 2, brk_cnt)
   endtask
   task automatic t_operand;
      bus(1'b1, 16'hfe0a, 8'h05);
      bus(1'b1, 16'hfe0b, 8'h80);
      wait_ev(1'b1);
      `CHK("hit", 16'h8006, hit_addr)
      bus(1'b1, 16'hfe0b, 8'h00);
      wait_ev(1'b0);
   endtask
   task automatic t_soft;
      monitor_mode <= 1'b1;
      bus(1'b1, 16'hfe0b, 8'h40);
      wait_ev(1'b1);
      `CHK("vector", 16'hfefc, break_cmd.vector_addr)
      `CHK("at start", 1'b1, hit_of)
      `CHK("breaks", 4, brk_cnt)
      bus(1'b1, 16'hfe0b, 8'h00);
      wait_ev(1'b0);
      monitor_mode <= 1'b0;
   endtask
   task automatic t_data;
      bus(1'b1, 16'hfe09, 8'h00);
      bus(1'b1, 16'hfe0a, 8'h40);
      bus(1'b1, 16'hfe0b, 8'h80);
      n0 = brk_cnt;
      repeat (60) @(posedge clk);
      `CHK("breaks", n0, brk_cnt)
      bus(1'b1, 16'hfe0b, 8'h00);
   endtask
   task automatic t_wait;
      @(posedge clk);
      wait_exit_by_break <= 1'b1;
      @(posedge clk);
      wait_exit_by_break <= 1'b0;
      rchk(16'hfe00, 8'h02);
      bus(1'b1, 16'hfe00, 8'h00);
      rchk(16'hfe00, 8'h00);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_match();
      t_operand();
      t_soft();
      t_data();
      t_wait();
      end_of_test();
   end

   // Hang guard
   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end
endmodule
`default_nettype wire
